// ==== hmtc_pkg.sv ====
`default_nettype none
package hmtc_pkg;
    localparam logic [7:0] ADDR_ALERT_MASK_SECOND = 8'h75;
    localparam logic [7:0] ADDR_LOW_BITS_VOLTAGES = 8'h76;
    localparam logic [7:0] ADDR_LOW_BITS_MIXED = 8'h77;
    localparam logic [7:0] ADDR_THIRD_CONFIGURATION = 8'h78;
    localparam logic [7:0] ADDR_THERMAL_STATUS = 8'h79;

    localparam logic [7:0] RST_ALERT_MASK_SECOND = 8'h00;
    localparam logic [7:0] RST_THIRD_CONFIGURATION = 8'h00;
    localparam logic [7:0] RST_THERMAL_STATUS = 8'h00;
    localparam logic [7:0] RST_LOW_BITS = 8'h00;

    // mask bit positions
    localparam int MSK_TWELVE_VOLT = 0;
    localparam int MSK_OVERTEMP = 1;
    localparam int MSK_FAN4_OR_TIMER = 5;
    // third configuration bit positions
    localparam int CFG_ALERT_PIN = 0;
    localparam int CFG_THERMAL_EN = 1;
    localparam int CFG_FAILSAFE = 2;
    localparam int CFG_FAST_TACH = 3;
    localparam int CFG_CONT_LO = 4;

    localparam int CLK_PERIOD_NS = 40;
    localparam int STEP_TIME_NS = 22760000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    // reading shows the count only once assertion exceeds two steps
    localparam logic [7:0] EXCEED_STEPS = 8'h02;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
endpackage
`default_nettype wire

// ==== hmtc_regs.sv ====
`default_nettype none
// Functional notes
// - mask bit 0 set blocks alert for twelve-volt channel faults.
// - mask bit 1 never blocks overtemperature alert: it stays zero and cannot be written by host.
// - mask bits 2..4 block alerts for fan 1..3 faults.
// - mask bit 5 blocks fan 4 fault, or timer event when fan 4 pin is thermal.
// - mask bits 6,7 block alerts for remote 1 and 2 diode faults.
// - alert mask register resets to all zeros.
// - first low-bits register packs 2.5V, core, 3.3V, 5V low bits.
// - second low-bits register packs 12V, remote1, local, remote2 low bits.
// - reading low-bits register freezes it until its high bytes are read.
// - config bit 0 turns second fan drive pin into the alert output.
// - config bit 1 enables thermal input monitoring on the selected pin.
// - config bit 2: thermal assertion forces all fans to full speed.
// - config bit 3 selects 250 ms tach period instead of one second.
// - config bits 4..7 select continuous tach on inputs 1..4.
// - lock bit set makes the third configuration register ignore writes.
// - status bit 0 sets on thermal assertion and clears on host read.
// - status bits 7:1 read zero until assertion exceeds 45.52 ms.
// - beyond 45.52 ms status shows 8-bit count in 22.76 ms steps.
// - third configuration register resets to all zeros.
// - assertion time beyond limit raises limit event; zero limit fires at once.
module hmtc_regs #(
    parameter int STEP_CYCLES = hmtc_pkg::STEP_CYCLES,
    parameter int PRE_W = 20
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    input wire logic config_lock,
    input wire logic thermal_pin_select,
    input wire logic thermal_5v_pin_b,
    input wire logic fan4_speed_input,
    input wire logic [7:0] thermal_limit,
    input wire logic [7:0] voltage_low_bits,
    input wire logic [7:0] mixed_low_bits,
    input wire logic conversion_update,
    input wire logic voltage_high_read_done,
    input wire logic mixed_high_read_done,
    input wire logic [7:0] fault_status,
    input wire logic fan4_fault_status,
    input wire logic timer_event_status,
    input wire logic pwm_two_in,
    output logic fan_drive_output_two_r,
    output logic alert_out_b_r,
    output logic failsafe_full_speed_r,
    output logic fast_tach_r,
    output logic [3:0] continuous_speed_r,
    output logic voltage_frozen_r,
    output logic mixed_frozen_r,
    output logic thermal_limit_event_r
);
    import hmtc_pkg::*;

    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

    logic [7:0] mask_r;
    logic [7:0] cfg_r;
    logic [7:0] low_v_r;
    logic [7:0] low_m_r;
    logic [1:0] sync_5v_r;
    logic [1:0] sync_t4_r;
    logic therm_prev_r;
    logic seen_r;
    logic [7:0] count_r;
    logic [PRE_W-1:0] pre_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    wire wr_mask = reg_wr && hit(reg_addr, ADDR_ALERT_MASK_SECOND);
    wire wr_cfg = reg_wr && hit(reg_addr, ADDR_THIRD_CONFIGURATION) && !config_lock;
    wire rd_low_v = reg_rd && hit(reg_addr, ADDR_LOW_BITS_VOLTAGES);
    wire rd_low_m = reg_rd && hit(reg_addr, ADDR_LOW_BITS_MIXED);
    wire rd_status = reg_rd && hit(reg_addr, ADDR_THERMAL_STATUS);

    // the selected pin is sampled only after both stages of its own synchroniser
    wire pin_low = thermal_pin_select ? !sync_5v_r[1] : !sync_t4_r[1];
    wire therm_act = cfg_r[CFG_THERMAL_EN] && pin_low;
    wire therm_rise = therm_act && !therm_prev_r;
    wire step_tick = therm_act && (pre_r == PRE_LAST);
    wire count_sat = (count_r == COUNT_MAX);
    wire exceeded = (count_r >= EXCEED_STEPS);
    wire [7:0] status_view = exceeded ? count_r : {7'h00, seen_r};
    wire fan4_speed_input_thermal = cfg_r[CFG_THERMAL_EN] && !thermal_pin_select;
    wire bit5_src = fan4_speed_input_thermal ? timer_event_status : fan4_fault_status;
    wire [7:0] alert_src = {fault_status[7:6], bit5_src, fault_status[4:0]};
    wire alert_any = |(alert_src & ~mask_r);
    wire limit_hit = (thermal_limit == 8'h00) ? therm_rise
                   : (step_tick && (count_r == thermal_limit));
    wire [7:0] mask_wr = {reg_wdata[7:2], 1'b0, reg_wdata[0]};

    wire [7:0] rdata_nxt =
        hit(reg_addr, ADDR_ALERT_MASK_SECOND) ? mask_r :
        hit(reg_addr, ADDR_LOW_BITS_VOLTAGES) ? low_v_r :
        hit(reg_addr, ADDR_LOW_BITS_MIXED) ? low_m_r :
        hit(reg_addr, ADDR_THIRD_CONFIGURATION) ? cfg_r :
        hit(reg_addr, ADDR_THERMAL_STATUS) ? status_view : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= RST_ALERT_MASK_SECOND;
            cfg_r <= RST_THIRD_CONFIGURATION;
        end else begin
            if (wr_mask) begin
                mask_r <= mask_wr;
            end
            if (wr_cfg) begin
                cfg_r <= reg_wdata;
            end
        end
    end

    // a read that coincides with the high-byte release still freezes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            voltage_frozen_r <= 1'b0;
            mixed_frozen_r <= 1'b0;
            low_v_r <= RST_LOW_BITS;
            low_m_r <= RST_LOW_BITS;
        end else begin
            voltage_frozen_r <= rd_low_v || (voltage_frozen_r && !voltage_high_read_done);
            mixed_frozen_r <= rd_low_m || (mixed_frozen_r && !mixed_high_read_done);
            if (conversion_update && !voltage_frozen_r) begin
                low_v_r <= voltage_low_bits;
            end
            if (conversion_update && !mixed_frozen_r) begin
                low_m_r <= mixed_low_bits;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_5v_r <= 2'b11;
            sync_t4_r <= 2'b11;
            therm_prev_r <= 1'b0;
        end else begin
            sync_5v_r <= {sync_5v_r[0], thermal_5v_pin_b};
            sync_t4_r <= {sync_t4_r[0], fan4_speed_input};
            therm_prev_r <= therm_act;
        end
    end

    // timer restarts on each new assertion; a read while idle clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_r <= 1'b0;
            count_r <= RST_THERMAL_STATUS;
            pre_r <= '0;
        end else begin
            seen_r <= therm_rise || (seen_r && !rd_status);
            if (therm_rise) begin
                count_r <= 8'h00;
            end else if (step_tick && !count_sat) begin
                count_r <= count_r + 8'h01;
            end else if (rd_status && !therm_act) begin
                count_r <= 8'h00;
            end
            if (!therm_act || therm_rise || pre_r == PRE_LAST) begin
                pre_r <= '0;
            end else begin
                pre_r <= pre_r + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r <= 8'h00;
            alert_out_b_r <= 1'b1;
            fan_drive_output_two_r <= 1'b0;
            failsafe_full_speed_r <= 1'b0;
            fast_tach_r <= 1'b0;
            continuous_speed_r <= 4'h0;
            thermal_limit_event_r <= 1'b0;
        end else begin
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
            end
            alert_out_b_r <= !alert_any;
            fan_drive_output_two_r <= cfg_r[CFG_ALERT_PIN] ? !alert_any : pwm_two_in;
            failsafe_full_speed_r <= cfg_r[CFG_FAILSAFE] && therm_act;
            fast_tach_r <= cfg_r[CFG_FAST_TACH];
            continuous_speed_r <= cfg_r[CFG_CONT_LO +: 4];
            thermal_limit_event_r <= limit_hit;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_rise;
        therm_rise;
    endsequence
    sequence s_seen_held;
        seen_r;
    endsequence

    chk_mask_reset_low: assert property (wr_mask |=> !mask_r[MSK_OVERTEMP])
        else $error("overtemp mask bit became writable");
    chk_mask_write: assert property (wr_mask |=> mask_r[0] == $past(reg_wdata[0]))
        else $error("mask bit 0 not stored");
    chk_cfg_lock: assert property (reg_wr && config_lock && $stable(cfg_r) |=> $stable(cfg_r))
        else $error("third configuration changed while locked");
    chk_freeze_hold: assert property (voltage_frozen_r && conversion_update |=> $stable(low_v_r))
        else $error("frozen low bits updated");
    chk_seen_set: assert property (s_rise ##1 !rd_status |=> seen_r)
        else $error("assertion flag not set");
    chk_seen_clear: assert property (rd_status && !therm_rise |=> !seen_r)
        else $error("assertion flag not cleared on read");
    chk_seen_stay: assert property (s_rise ##1 (!rd_status [*2]) |-> s_seen_held)
        else $error("assertion flag dropped without read");
    chk_timer_zero: assert property (count_r < EXCEED_STEPS |-> status_view[7:1] == 7'h00)
        else $error("timer bits nonzero before threshold");
    // a new assertion restarts the count, so a full count from an earlier one is exempt
    chk_count_sat: assert property (count_sat && therm_act && !therm_rise |=> count_r == COUNT_MAX)
        else $error("count wrapped");
    chk_alert_mask: assert property (alert_src[0] && !mask_r[0] |=> !alert_out_b_r)
        else $error("unmasked source gave no alert");
    chk_alert_pin: assert property (cfg_r[CFG_ALERT_PIN] |=> fan_drive_output_two_r == alert_out_b_r)
        else $error("alert pin function not applied");
    chk_failsafe_full_speed: assert property (therm_act && cfg_r[CFG_FAILSAFE] |=> failsafe_full_speed_r)
        else $error("fail-safe failsafe_full_speed missing");
    chk_zero_limit: assert property (therm_rise && thermal_limit == 8'h00 |=> thermal_limit_event_r)
        else $error("zero limit did not fire");

    // alert sources against their mask bits
    chk_fan_mask: assert property (
        (alert_src[4:2] & ~mask_r[4:2]) != 3'b000 |=> !alert_out_b_r)
        else $error("unmasked fan fault gave no alert");
    chk_bit5_timer: assert property (
        fan4_speed_input_thermal && timer_event_status && !mask_r[MSK_FAN4_OR_TIMER] |=> !alert_out_b_r)
        else $error("timer event gave no alert on fan 4 pin");
    chk_diode_mask: assert property (
        (alert_src[7:6] & ~mask_r[7:6]) != 2'b00 |=> !alert_out_b_r)
        else $error("unmasked diode fault gave no alert");
    chk_all_masked: assert property (
        (alert_src & ~mask_r) == 8'h00 |=> alert_out_b_r)
        else $error("alert raised with every source masked");
    chk_mask_store: assert property (
        wr_mask |=> mask_r[7:2] == $past(reg_wdata[7:2]))
        else $error("upper mask bits not stored");
    chk_mask_rd: assert property (
        reg_rd && hit(reg_addr, ADDR_ALERT_MASK_SECOND) |=> reg_rdata_r == $past(mask_r))
        else $error("mask read data wrong");

    // low-bit packs and their freeze
    chk_low_v_read: assert property (
        rd_low_v |=> reg_rdata_r == $past(low_v_r))
        else $error("voltage low bits read wrong");
    chk_low_m_read: assert property (
        rd_low_m |=> reg_rdata_r == $past(low_m_r))
        else $error("mixed low bits read wrong");
    chk_freeze_set: assert property (
        rd_low_v |=> voltage_frozen_r)
        else $error("voltage freeze not set by read");
    chk_freeze_m_hold: assert property (
        mixed_frozen_r && conversion_update |=> $stable(low_m_r))
        else $error("frozen mixed low bits updated");

    // configuration outputs
    chk_cfg_write: assert property (
        wr_cfg |=> cfg_r == $past(reg_wdata))
        else $error("third configuration write lost");
    chk_cfg_rd: assert property (
        reg_rd && hit(reg_addr, ADDR_THIRD_CONFIGURATION) |=> reg_rdata_r == $past(cfg_r))
        else $error("third configuration read wrong");
    chk_therm_off: assert property (
        !cfg_r[CFG_THERMAL_EN] |-> !therm_act)
        else $error("thermal input active while disabled");
    chk_failsafe_full_speed_off: assert property (
        !therm_act |=> !failsafe_full_speed_r)
        else $error("failsafe_full_speed without thermal assertion");
    chk_fast_tach: assert property (
        cfg_r[CFG_FAST_TACH] |=> fast_tach_r)
        else $error("fast tach not applied");
    chk_cont_tach: assert property (
        1'b1 |=> continuous_speed_r == $past(cfg_r[CFG_CONT_LO +: 4]))
        else $error("continuous tach bits not applied");
    chk_pin_two_pwm: assert property (
        !cfg_r[CFG_ALERT_PIN] |=> fan_drive_output_two_r == $past(pwm_two_in))
        else $error("fan drive two lost its waveform");

    // assertion timer and status view
    chk_count_step: assert property (
        step_tick && !count_sat && !therm_rise |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not advance on step");
    chk_count_restart: assert property (
        therm_rise |=> count_r == 8'h00)
        else $error("count not restarted on new assertion");
    chk_count_idle: assert property (
        !therm_act && !rd_status |=> $stable(count_r))
        else $error("count moved while idle");
    chk_status_read: assert property (
        rd_status && exceeded |=> reg_rdata_r == $past(count_r))
        else $error("status did not show full count");
    chk_seen_status: assert property (
        rd_status && !exceeded |=> reg_rdata_r == {7'h00, $past(seen_r)})
        else $error("status did not show assertion flag");
    chk_limit_step: assert property (
        step_tick && thermal_limit != 8'h00 && count_r == thermal_limit |=> thermal_limit_event_r)
        else $error("limit passed without event");
    chk_limit_quiet: assert property (
        thermal_limit != 8'h00 && !(step_tick && count_r == thermal_limit)
        |=> !thermal_limit_event_r)
        else $error("limit event without limit passed");
endmodule
`default_nettype wire

// ==== hmtc_host.sv ====
`default_nettype none
// register-port master standing in for the serial host engine
module hmtc_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // every call starts on a fresh edge, so strobes never run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        // released data no longer shows the last value
        reg_wdata = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        v = reg_rdata_r;
        reg_rd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== test_alert_mask_tach_config_thermal_timer.sv ====
`default_nettype none
module test_alert_mask_tach_config_thermal_timer;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, reg_wr, reg_rd, config_lock = 0, thermal_pin_select = 1;
    logic thermal_5v_pin_b = 1, fan4_speed_input = 1, conversion_update = 0, pwm_two_in = 0;
    logic voltage_high_read_done = 0, mixed_high_read_done = 0, fan4_fault_status = 0;
    logic timer_event_status = 0, fan_drive_output_two_r, alert_out_b_r, failsafe_full_speed_r;
    logic fast_tach_r, voltage_frozen_r, mixed_frozen_r, thermal_limit_event_r;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d, thermal_limit = 0, fault_status = 0;
    logic [7:0] voltage_low_bits = 0, mixed_low_bits = 0;
    logic [3:0] continuous_speed_r;
    int err_total = 0, n_tests = 0, ev_cnt = 0;
    hmtc_regs #(.STEP_CYCLES(8)) hmtc_regs_inst (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata_r, .config_lock, .thermal_pin_select, .thermal_5v_pin_b,
        .fan4_speed_input, .thermal_limit, .voltage_low_bits, .mixed_low_bits,
        .conversion_update, .voltage_high_read_done, .mixed_high_read_done, .fault_status,
        .fan4_fault_status, .timer_event_status, .pwm_two_in, .fan_drive_output_two_r,
        .alert_out_b_r, .failsafe_full_speed_r, .fast_tach_r, .continuous_speed_r,
        .voltage_frozen_r, .mixed_frozen_r, .thermal_limit_event_r);
    hmtc_host hmtc_host_inst (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r);
    always #20 clk = ~clk;
    always @(posedge clk) if (thermal_limit_event_r === 1'b1) ev_cnt++;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic upd();
        tick(1);
        conversion_update = 1;
        tick(1);
        conversion_update = 0;
    endtask
    task automatic t_reset();
        // 0x7A lies outside the block and must read zero
        for (int a = 'h75; a < 'h7B; a++) begin
            hmtc_host_inst.rd(8'(a), d);
            chk(d, 8'h00);
        end
        // those reads froze both packs; release them before later scenarios
        chk({6'h00, voltage_frozen_r, mixed_frozen_r}, 8'h03);
        voltage_high_read_done = 1;
        mixed_high_read_done = 1;
        tick(1);
        voltage_high_read_done = 0;
        mixed_high_read_done = 0;
        chk({6'h00, voltage_frozen_r, mixed_frozen_r}, 8'h00);
    endtask
    task automatic t_mask();
        hmtc_host_inst.wr(8'h75, 8'hFF);
        hmtc_host_inst.rd(8'h75, d);
        chk(d, 8'hFD);
        for (int i = 0; i < 8; i++) begin
            if (i == 1) continue;
            hmtc_host_inst.wr(8'h75, 8'h00);
            fault_status = 8'(1 << i);
            fan4_fault_status = (i == 5);
            tick(3);
            chk({7'h0, alert_out_b_r}, 8'h00);
            hmtc_host_inst.wr(8'h75, 8'(1 << i));
            tick(3);
            chk({7'h0, alert_out_b_r}, 8'h01);
        end
        hmtc_host_inst.wr(8'h75, 8'h00);
        hmtc_host_inst.wr(8'h78, 8'h01);
        pwm_two_in = 1;
        tick(3);
        chk({7'h0, fan_drive_output_two_r}, 8'h00);
        hmtc_host_inst.wr(8'h78, 8'h00);
        tick(3);
        chk({7'h0, fan_drive_output_two_r}, 8'h01);
        fault_status = 0;
        fan4_fault_status = 0;
    endtask
    task automatic t_cfg();
        hmtc_host_inst.wr(8'h78, 8'h58);
        hmtc_host_inst.rd(8'h78, d);
        chk(d, 8'h58);
        chk({3'h0, continuous_speed_r, fast_tach_r}, 8'h0B);
        config_lock = 1;
        hmtc_host_inst.wr(8'h78, 8'h00);
        hmtc_host_inst.rd(8'h78, d);
        chk(d, 8'h58);
        config_lock = 0;
    endtask
    task automatic t_freeze();
        voltage_low_bits = 8'hA5;
        mixed_low_bits = 8'h96;
        upd();
        hmtc_host_inst.rd(8'h77, d);
        chk(d, 8'h96);
        hmtc_host_inst.rd(8'h76, d);
        chk(d, 8'hA5);
        voltage_low_bits = 8'h3C;
        upd();
        chk({7'h0, voltage_frozen_r}, 8'h01);
        hmtc_host_inst.rd(8'h76, d);
        chk(d, 8'hA5);
        voltage_high_read_done = 1;
        tick(1);
        voltage_high_read_done = 0;
        upd();
        hmtc_host_inst.rd(8'h76, d);
        chk(d, 8'h3C);
    endtask
    task automatic t_therm();
        hmtc_host_inst.wr(8'h78, 8'h06);
        thermal_5v_pin_b = 0;
        tick(5);
        chk({7'h0, failsafe_full_speed_r}, 8'h01);
        chk(8'(ev_cnt), 8'h01);
        hmtc_host_inst.rd(8'h79, d);
        chk(d, 8'h01);
        tick(40);
        hmtc_host_inst.rd(8'h79, d);
        chk({7'h0, d > 8'h01}, 8'h01);
        // long enough for the count to reach its all-ones value and saturate there
        tick(2100);
        hmtc_host_inst.rd(8'h79, d);
        chk(d, 8'hFF);
        thermal_5v_pin_b = 1;
        tick(5);
        chk({7'h0, failsafe_full_speed_r}, 8'h00);
        hmtc_host_inst.rd(8'h79, d);
        chk(d, 8'hFF);
        hmtc_host_inst.rd(8'h79, d);
        chk(d, 8'h00);
    endtask
    task automatic t_limit();
        thermal_limit = 8'h03;
        thermal_pin_select = 0;
        ev_cnt = 0;
        hmtc_host_inst.wr(8'h75, 8'h00);
        timer_event_status = 1;
        tick(3);
        chk({7'h0, alert_out_b_r}, 8'h00);
        hmtc_host_inst.wr(8'h75, 8'h20);
        tick(3);
        chk({7'h0, alert_out_b_r}, 8'h01);
        timer_event_status = 0;
        fan4_speed_input = 0;
        tick(20);
        chk(8'(ev_cnt), 8'h00);
        tick(40);
        chk(8'(ev_cnt), 8'h01);
        hmtc_host_inst.rd(8'h79, d);
        chk({7'h0, d >= 8'h04}, 8'h01);
        fan4_speed_input = 1;
        tick(5);
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #1ms;
        err_total++;
        test_done();
    end
    initial begin
        tick(12);
        rst_b = 1;
        t_reset();
        t_mask();
        t_cfg();
        t_freeze();
        t_therm();
        t_limit();
        test_done();
    end
endmodule
`default_nettype wire
